// [tb/sfc_modem_model.sv]
// Far-side modem model on the request and clear-to-send lines.
// Assumes the bench passes the device pin drive and its own controls.
`timescale 1ns/1ps
module sfc_modem_model (
  input wire logic dev_rts_i,
  input wire logic dev_oe_i,
  input wire logic drive_i,
  input wire logic level_i,
  input wire logic cts_level_i,
  output logic rts_wire_o,
  output logic cts_pin_o
);
  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  // Pull-up wins when nobody drives, so a released line reads high
  assign rts_wire_o = dev_oe_i ? dev_rts_i :
                      (drive_i ? level_i : 1'b1);
  // Ready line of the remote side, active low
  assign cts_pin_o = cts_level_i;
endmodule

// [tb/sfc_serial_status_tb.sv]
// Self-checking bench for the serial status block, channels 0 and 2.
// Assumes the modem model resolves the request wire of channel 0.
`timescale 1ns/1ps
module sfc_serial_status_tb;
  import sfc_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [3:0] ev = 4'h0; // Tx push, tx pop, rx push, rx pop
  logic flow_n = 1'b1; // Request level from flow logic
  logic ext_drv = 1'b0; // Remote side drives the request wire
  logic ext_lvl = 1'b1;
  logic cts_lvl = 1'b1;
  logic [DATA_W-1:0] rd0, rd2, q0, q2;
  logic txf, txe, rxf, rxe, flow_int, rts_o, rts_oe, cts_n, mfe, lpb;
  logic rts_w, cts_w, rts2_o, rts2_oe, mfe2, rts2_w;
  int bad_count = 0;
  int checked = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  // Channel two has no modem; its line simply pulls up when released
  assign rts2_w = rts2_oe ? rts2_o : 1'b1;

  // ****************************************************************
  // Instances
  // ****************************************************************
  sfc_serial_status #(.CHANNEL(0)) u_sfc_serial_status (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd0),
    .tx_push_i(ev[3]), .tx_pop_i(ev[2]), .rx_push_i(ev[1]),
    .rx_pop_i(ev[0]), .tx_full_o(txf), .tx_empty_o(txe),
    .rx_full_o(rxf), .rx_empty_o(rxe), .rts_flow_n_i(flow_n),
    .rts_flow_int_o(flow_int), .rts_pin_i(rts_w), .rts_pin_o(rts_o),
    .rts_pin_oe_o(rts_oe), .cts_pin_i(cts_w), .cts_active_n_o(cts_n),
    .modem_flow_enable_o(mfe), .loopback_o(lpb));
  // Second channel shares the bus so reserved bits can be compared
  sfc_serial_status #(.CHANNEL(CHAN_NO_FLOW)) u_sfc_serial_status_ch2 (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd2),
    .tx_push_i(ev[3]), .tx_pop_i(ev[2]), .rx_push_i(ev[1]),
    .rx_pop_i(ev[0]), .tx_full_o(), .tx_empty_o(), .rx_full_o(),
    .rx_empty_o(), .rts_flow_n_i(flow_n), .rts_flow_int_o(),
    .rts_pin_i(rts2_w), .rts_pin_o(rts2_o), .rts_pin_oe_o(rts2_oe),
    .cts_pin_i(cts_w), .cts_active_n_o(), .modem_flow_enable_o(mfe2),
    .loopback_o());
  sfc_modem_model u_sfc_modem_model (
    .dev_rts_i(rts_o), .dev_oe_i(rts_oe), .drive_i(ext_drv),
    .level_i(ext_lvl), .cts_level_i(cts_lvl), .rts_wire_o(rts_w),
    .cts_pin_o(cts_w));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr_en <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd_en <= 1'b0;
    #1;
    q0 = rd0;
    q2 = rd2;
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge clk_sys_i);
    ev <= v;
    @(posedge clk_sys_i);
    ev <= 4'h0;
    #1;
  endtask

  // Pins pass a two-flop synchroniser, so allow three edges
  task automatic settle();
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(OFF_FILL);
    chk("fill reset", FILL_RESET, q0);
    rd(OFF_PORT);
    // Data bits 4, 2 and 0 are not reset, so they are masked out
    chk("port reset", 16'h0040, q0 & 16'hFFEA);
    chk("rts oe reset", 1'b0, rts_oe);
    chk("cts internal", 1'b0, cts_n);
    chk("rts internal", 1'b0, flow_int);
    $display("test reset done");
  endtask

  task automatic t_counts();
    chk("tx empty", 1'b1, txe);
    pulse(4'h8);
    chk("tx empty after push", 1'b0, txe);
    for (int i = 0; i < 16; i++) pulse(4'hA);
    rd(OFF_FILL);
    chk("fill both full", 16'h1010, q0);
    chk("tx full", 1'b1, txf);
    chk("rx full", 1'b1, rxf);
    // At full the push is refused, so the pop beside it frees a slot
    pulse(4'hC);
    for (int i = 0; i < 13; i++) pulse(4'h1);
    rd(OFF_FILL);
    chk("fill partial", 16'h0F03, q0);
    wr(OFF_FILL, 16'h0000);
    rd(OFF_FILL);
    chk("fill after write", 16'h0F03, q0);
    for (int i = 0; i < 4; i++) pulse(4'h1);
    rd(OFF_FILL);
    chk("fill rx drained", 16'h0F00, q0);
    chk("rx empty", 1'b1, rxe);
    @(posedge clk_sys_i);
    #1;
    chk("read data dropped", DATA_ZERO, rd0);
    wr(OFF_FCTL, 16'h0006);
    pulse(4'h8);
    rd(OFF_FILL);
    chk("fill flushed", 16'h0000, q0);
    wr(OFF_FCTL, 16'h0000);
    rd(8'h0C);
    chk("unmapped read", DATA_ZERO, q0);
    $display("test counts done");
  endtask

  task automatic t_pin();
    // The pin is taken to be routed to the request function already
    wr(OFF_PORT, 16'h00AA);
    chk("rts oe driven", 1'b1, rts_oe);
    chk("rts low", 1'b0, rts_o);
    settle();
    rd(OFF_PORT);
    chk("port driven low", 16'h00AA, q0);
    wr(OFF_PORT, 16'h00C0);
    chk("rts high", 1'b1, rts_o);
    wr(OFF_PORT, 16'h0055);
    chk("rts released", 1'b0, rts_oe);
    @(posedge clk_sys_i);
    ext_drv <= 1'b1;
    ext_lvl <= 1'b0;
    settle();
    rd(OFF_PORT);
    chk("port remote low", 16'h0015, q0);
    @(posedge clk_sys_i);
    ext_drv <= 1'b0;
    settle();
    rd(OFF_PORT);
    chk("port pulled up", 16'h0055, q0);
    $display("test pin done");
  endtask

  task automatic t_flow();
    wr(OFF_FCTL, 16'h0008);
    chk("flow enable", 1'b1, mfe);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys_i);
      flow_n <= i[0];
      cts_lvl <= i[0];
      settle();
      chk("flow oe", 1'b1, rts_oe);
      chk("flow pin", i[0], rts_o);
      chk("flow internal", i[0], flow_int);
      chk("flow cts", i[0], cts_n);
    end
    wr(OFF_FCTL, 16'h0001);
    chk("loopback", 1'b1, lpb);
    chk("flow off cts", 1'b0, cts_n);
    chk("flow off internal", 1'b0, flow_int);
    chk("flow off oe", 1'b0, rts_oe);
    $display("test flow done");
  endtask

  // Channel two gets the forbidden writes on purpose and must ignore them
  task automatic t_chan2();
    wr(OFF_FCTL, 16'h0008);
    wr(OFF_PORT, 16'h00C0);
    chk("ch2 flow enable", 1'b0, mfe2);
    chk("ch2 rts oe", 1'b0, rts2_oe);
    rd(OFF_PORT);
    chk("ch2 port", 16'h0000, q2);
    $display("test channel two done");
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic final_report();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_counts();
    t_pin();
    t_flow();
    t_chan2();
    final_report();
  end

  // Watchdog so a hang still ends in the report
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    bad_count++;
    $display("BAD watchdog expected end seen timeout");
    final_report();
  end
endmodule

// [verilog/sfc_level_cnt.sv]
// Occupancy counter for one FIFO, fed by push and pop pulses.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
module sfc_level_cnt #(
  parameter int DEPTH = 16,
  parameter int CW = 5
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic pop_i,
  output logic [CW-1:0] level_o,
  output logic full_o,
  output logic empty_o
);

  // ****************************************************************
  // Counter
  // ****************************************************************
  localparam logic [CW-1:0] LVL_MAX = CW'(DEPTH); // Full count
  localparam logic [CW-1:0] LVL_ONE = CW'(1); // Step

  logic [CW-1:0] level_r; // Current occupancy
  logic [CW-1:0] level_nxt; // Next occupancy
  wire do_push = push_i && (level_r != LVL_MAX); // Overflow dropped
  wire do_pop = pop_i && (level_r != '0); // Underflow ignored

  // An accepted push and an accepted pop together leave the level alone
  assign level_nxt = flush_i ? '0 :
                     (do_push && !do_pop) ? level_r + LVL_ONE :
                     (do_pop && !do_push) ? level_r - LVL_ONE : level_r;

  // Level follows each byte at the edge it moves
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      level_r <= '0;
    end else begin
      level_r <= level_nxt;
    end
  end

  assign level_o = level_r;
  assign full_o = (level_r == LVL_MAX);
  assign empty_o = (level_r == '0);

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_level_bound: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    level_r <= LVL_MAX)
    else $error("Level above depth");

  a_push_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (push_i && !pop_i && !flush_i && !full_o) |=>
      level_r == $past(level_r) + LVL_ONE)
    else $error("Push did not raise level");

endmodule

// [verilog/sfc_pkg.sv]
// Constants shared by the serial status block and its level counter.
// Assumes a 16-bit register port and a single 100 MHz system clock.
package sfc_pkg;

  // ****************************************************************
  // Register port geometry
  // ****************************************************************
  localparam int ADDR_W = 8; // Register address width
  localparam int DATA_W = 16; // Register data width
  localparam int CNT_W = 5; // Width of one occupancy field
  localparam int FIFO_DEPTH = 16; // Bytes per FIFO

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_FILL = 8'h00; // fifo_fill_level
  localparam logic [ADDR_W-1:0] OFF_PORT = 8'h04; // serial_pin_port
  localparam logic [ADDR_W-1:0] OFF_FCTL = 8'h08; // fifo_control_register

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FILL_TX_LSB = 8; // Transmit count low bit
  localparam int FILL_RX_LSB = 0; // Receive count low bit
  localparam int PORT_USED_W = 8; // Implemented low bits of port reg
  localparam int BIT_RTS_DIR = 7; // request_pin_direction
  localparam int BIT_RTS_LVL = 6; // request_pin_level
  localparam int BIT_CTS_DIR = 5; // Clear-to-send direction
  localparam int BIT_SCK_DIR = 3; // Serial clock direction
  localparam int BIT_BRK_DIR = 1; // Break direction
  localparam int BIT_MFE = 3; // modem_flow_enable
  localparam int BIT_TX_RST = 2; // Transmit FIFO flush
  localparam int BIT_RX_RST = 1; // Receive FIFO flush
  localparam int BIT_LOOP = 0; // Loop-back

  // ****************************************************************
  // Reset values and channel numbers
  // ****************************************************************
  localparam logic [DATA_W-1:0] FILL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [3:0] FCTL_RESET = 4'h0;
  localparam int CHAN_NO_FLOW = 2; // Channel without flow control

endpackage

// [verilog/sfc_serial_status.sv]
// Fill-level and pin-port registers of one serial channel.
// Assumes FIFO push/pop pulses from same-clock logic, pins from outside.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

// How it works
// - Fill register: tx count high, rx low
// - Tx count 0 empty, 0x10 full
// - Rx count 0 empty, 0x10 full
// - Fill register read-only, resets to zero
// - Unused bits read zero, write zero
// - Port register bit pairs; only the request pair governs a pin
// - Port register R/W; bits 7,5,3,1 reset
// - Request pin: input, driven, or flow-controlled
// - Request level reads the sampled pin
// - Channel two: request bits reserved, inert
// - Flow enable only channels 0 and 1
// - Flow off: clear-to-send active, request zero
module sfc_serial_status
  import sfc_pkg::*;
#(
  parameter int CHANNEL = 0,
  parameter int DEPTH = sfc_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [sfc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [sfc_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [sfc_pkg::DATA_W-1:0] rd_data_o,
  input wire logic tx_push_i,
  input wire logic tx_pop_i,
  input wire logic rx_push_i,
  input wire logic rx_pop_i,
  output logic tx_full_o,
  output logic tx_empty_o,
  output logic rx_full_o,
  output logic rx_empty_o,
  input wire logic rts_flow_n_i,
  output logic rts_flow_int_o,
  input wire logic rts_pin_i,
  output logic rts_pin_o,
  output logic rts_pin_oe_o,
  input wire logic cts_pin_i,
  output logic cts_active_n_o,
  output logic modem_flow_enable_o,
  output logic loopback_o
);
  import sfc_pkg::*;

  // ****************************************************************
  // Channel options
  // ****************************************************************
  // The channel without flow control keeps request bits and the
  // flow enable tied off, so a stray write cannot move the pin
  localparam bit HAS_FLOW = (CHANNEL != CHAN_NO_FLOW);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire hit_fill = (addr_i == OFF_FILL); // Fill-level select
  wire hit_port = (addr_i == OFF_PORT); // Port select
  wire hit_fctl = (addr_i == OFF_FCTL); // FIFO control select
  wire wr_port = wr_en_i && hit_port; // Port write
  wire wr_fctl = wr_en_i && hit_fctl; // Control write

  // ****************************************************************
  // FIFO control register (flow enable, flushes, loop-back)
  // ****************************************************************
  logic mfe_r; // modem_flow_enable
  logic tx_rst_r; // Transmit FIFO held empty
  logic rx_rst_r; // Receive FIFO held empty
  logic loop_r; // Loop-back
  wire mfe_wr = wr_data_i[BIT_MFE] && HAS_FLOW;

  // Control bits; flow enable stays zero where it does not exist
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {mfe_r, tx_rst_r, rx_rst_r, loop_r} <= FCTL_RESET;
    end else if (wr_fctl) begin
      mfe_r <= mfe_wr;
      tx_rst_r <= wr_data_i[BIT_TX_RST];
      rx_rst_r <= wr_data_i[BIT_RX_RST];
      loop_r <= wr_data_i[BIT_LOOP];
    end
  end

  assign modem_flow_enable_o = mfe_r;
  assign loopback_o = loop_r;

  // ****************************************************************
  // Occupancy counters
  // ****************************************************************
  logic [CNT_W-1:0] tx_level; // Untransmitted bytes
  logic [CNT_W-1:0] rx_level; // Received bytes waiting

  // Transmit FIFO occupancy
  sfc_level_cnt #(
    .DEPTH(DEPTH),
    .CW(CNT_W)
  ) u_tx_level (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .flush_i(tx_rst_r),
    .push_i(tx_push_i),
    .pop_i(tx_pop_i),
    .level_o(tx_level),
    .full_o(tx_full_o),
    .empty_o(tx_empty_o)
  );

  // Receive FIFO occupancy
  sfc_level_cnt #(
    .DEPTH(DEPTH),
    .CW(CNT_W)
  ) u_rx_level (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .flush_i(rx_rst_r),
    .push_i(rx_push_i),
    .pop_i(rx_pop_i),
    .level_o(rx_level),
    .full_o(rx_full_o),
    .empty_o(rx_empty_o)
  );

  // Fill register image; unused bits are constant zero
  logic [DATA_W-1:0] fill_word; // fifo_fill_level view
  always_comb begin
    fill_word = FILL_RESET;
    fill_word[FILL_TX_LSB +: CNT_W] = tx_level;
    fill_word[FILL_RX_LSB +: CNT_W] = rx_level;
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic rts_meta_r; // First stage, read only by the second
  logic rts_sync_r; // Sampled request pin
  logic cts_meta_r; // First stage, read only by the second
  logic cts_sync_r; // Sampled clear-to-send pin

  // Two flops per pin; reset to the idle high level of both lines
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rts_meta_r <= 1'b1;
      rts_sync_r <= 1'b1;
      cts_meta_r <= 1'b1;
      cts_sync_r <= 1'b1;
    end else begin
      rts_meta_r <= rts_pin_i;
      rts_sync_r <= rts_meta_r;
      cts_meta_r <= cts_pin_i;
      cts_sync_r <= cts_meta_r;
    end
  end

  // ****************************************************************
  // Port register
  // ****************************************************************
  logic rts_dir_r; // request_pin_direction
  logic cts_dir_r; // Clear-to-send direction
  logic sck_dir_r; // Serial clock direction
  logic brk_dir_r; // Break direction
  logic rts_lvl_r; // request_pin_level as written
  logic cts_lvl_r; // Clear-to-send level as written
  logic sck_lvl_r; // Serial clock level as written
  logic brk_lvl_r; // Break level as written

  // Direction bits carry a power-on value
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rts_dir_r <= 1'b0;
      cts_dir_r <= 1'b0;
      sck_dir_r <= 1'b0;
      brk_dir_r <= 1'b0;
    end else if (wr_port) begin
      rts_dir_r <= wr_data_i[BIT_RTS_DIR] && HAS_FLOW;
      cts_dir_r <= wr_data_i[BIT_CTS_DIR];
      sck_dir_r <= wr_data_i[BIT_SCK_DIR];
      brk_dir_r <= wr_data_i[BIT_BRK_DIR];
    end
  end

  // Data bits keep no power-on value; the pin is not driven until
  // the request direction bit or flow enable is set, so an unknown level cannot escape
  always_ff @(posedge clk_sys_i) begin
    if (wr_port) begin
      rts_lvl_r <= wr_data_i[BIT_RTS_LVL];
      cts_lvl_r <= wr_data_i[BIT_CTS_DIR-1];
      sck_lvl_r <= wr_data_i[BIT_SCK_DIR-1];
      brk_lvl_r <= wr_data_i[BIT_BRK_DIR-1];
    end
  end

  // Read view: request level is the pin, not the stored bit
  logic [DATA_W-1:0] port_word; // serial_pin_port view
  always_comb begin
    port_word = DATA_ZERO;
    port_word[BIT_RTS_DIR] = rts_dir_r && HAS_FLOW;
    port_word[BIT_RTS_LVL] = rts_sync_r && HAS_FLOW;
    port_word[BIT_CTS_DIR] = cts_dir_r;
    port_word[BIT_CTS_DIR-1] = cts_lvl_r;
    port_word[BIT_SCK_DIR] = sck_dir_r;
    port_word[BIT_SCK_DIR-1] = sck_lvl_r;
    port_word[BIT_BRK_DIR] = brk_dir_r;
    port_word[BIT_BRK_DIR-1] = brk_lvl_r;
  end

  logic [DATA_W-1:0] fctl_word; // fifo_control_register view
  always_comb begin
    fctl_word = DATA_ZERO;
    fctl_word[BIT_MFE] = mfe_r;
    fctl_word[BIT_TX_RST] = tx_rst_r;
    fctl_word[BIT_RX_RST] = rx_rst_r;
    fctl_word[BIT_LOOP] = loop_r;
  end

  // ****************************************************************
  // Request and clear-to-send pins
  // ****************************************************************
  // Flow logic request is forced to zero with flow control off
  wire flow_on = mfe_r && HAS_FLOW;
  assign rts_flow_int_o = flow_on ? rts_flow_n_i : 1'b0;
  // Clear-to-send seen as active (low) unless flow control is on
  assign cts_active_n_o = flow_on ? cts_sync_r : 1'b0;

  // Flow logic wins; else the direction bit picks input or drive
  assign rts_pin_oe_o = flow_on || (rts_dir_r && HAS_FLOW);
  assign rts_pin_o = flow_on ? rts_flow_n_i :
                     rts_pin_oe_o ? rts_lvl_r : 1'b0;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Unmapped addresses read zero; the fill register ignores writes
  wire [DATA_W-1:0] rd_mux = hit_fill ? fill_word :
                             hit_port ? port_word :
                             hit_fctl ? fctl_word : DATA_ZERO;

  // Data stand for the one cycle after the read strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rd_data_o <= DATA_ZERO;
    end else if (rd_en_i) begin
      rd_data_o <= rd_mux;
    end else begin
      rd_data_o <= DATA_ZERO;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_fill_read;
    rd_en_i && hit_fill;
  endsequence

  sequence s_port_read;
    rd_en_i && hit_port;
  endsequence

  a_fill_layout: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    s_fill_read |=> rd_data_o[FILL_TX_LSB +: CNT_W] == $past(tx_level)
      && rd_data_o[FILL_RX_LSB +: CNT_W] == $past(rx_level))
    else $error("Fill read mismatch");

  a_fill_zeros: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    s_fill_read |=> rd_data_o[15:13] == 3'h0 && rd_data_o[7:5] == 3'h0)
    else $error("Fill reserved bits set");

  a_port_zeros: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    s_port_read |=> rd_data_o[15:8] == 8'h00)
    else $error("Port reserved bits set");

  a_rts_readback: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (s_port_read ##0 HAS_FLOW) |=>
      rd_data_o[BIT_RTS_LVL] == $past(rts_sync_r))
    else $error("Request level not from pin");

  a_rts_input: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (!mfe_r && !rts_dir_r) |-> !rts_pin_oe_o)
    else $error("Request pin driven in input mode");

  a_rts_drive: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (wr_port && HAS_FLOW && !mfe_r && !wr_fctl
      && wr_data_i[BIT_RTS_DIR]) |=>
      rts_pin_oe_o && rts_pin_o == $past(wr_data_i[BIT_RTS_LVL]))
    else $error("Request pin not driven as written");

  a_flow_forced: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    !mfe_r |-> !rts_flow_int_o && !cts_active_n_o)
    else $error("Flow signals not forced");

  a_ch2_inert: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    !HAS_FLOW |-> !rts_pin_oe_o && !mfe_r)
    else $error("Channel without flow moved pin");

  a_fill_reset: assert property (@(posedge clk_sys_i)
    !rst_n_i |=> tx_level == '0 && rx_level == '0)
    else $error("Counts not cleared by reset");

  // Register and pin behaviour outside a read of the fill word

  a_rd_idle_zero: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    !rd_en_i |=> rd_data_o == DATA_ZERO)
    else $error("Read data without a read strobe");

  a_dir_reset: assert property (@(posedge clk_sys_i)
    !rst_n_i |=> !rts_dir_r && !cts_dir_r && !sck_dir_r && !brk_dir_r)
    else $error("Direction bits not cleared by reset");

  a_port_write: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    wr_port |=> cts_dir_r == $past(wr_data_i[BIT_CTS_DIR]))
    else $error("Port write not stored");

  a_mfe_write: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (wr_fctl && HAS_FLOW) |=> mfe_r == $past(wr_data_i[BIT_MFE]))
    else $error("Flow enable write not stored");

  a_flow_pin: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    flow_on |-> rts_pin_oe_o && rts_pin_o == rts_flow_n_i)
    else $error("Request pin not under flow logic");

  a_flow_pass: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    flow_on |-> rts_flow_int_o == rts_flow_n_i
      && cts_active_n_o == cts_sync_r)
    else $error("Flow signals not passed through");

endmodule
